// [logic/sece_pkg.sv]
// shared constants and carrier types of the serial eeprom command engine
package sece_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int PROG_TIME_TYP_NS = 4_000_000;
    localparam int PROG_TIME_MAX_NS = 10_000_000;
    localparam int PROG_TYP_CYC = PROG_TIME_TYP_NS / CLK_PERIOD_NS;
    localparam int PROG_MAX_CYC = PROG_TIME_MAX_NS / CLK_PERIOD_NS;
    localparam int PROG_CNT_W = 20;

    // ----------------------------------------
    // array geometry
    // ----------------------------------------
    localparam int WORD_W = 16;
    localparam int ADDR_W_SMALL = 8;
    localparam int ADDR_W_LARGE = 9;
    localparam int AFIELD_SMALL = 8;
    localparam int AFIELD_LARGE = 10;
    localparam int OP_W = 2;
    localparam int CMD_W_MAX = OP_W + AFIELD_LARGE;
    localparam int FIFO_DEPTH = 32;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [4:0] DATA_FULL_CNT = 5'h10;

    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_PROG = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] OP_MISC = 2'h0;
    localparam logic [1:0] MISC_ENABLE = 2'h3;
    localparam logic [1:0] MISC_DISABLE = 2'h0;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic cs;
        logic sk;
        logic di;
    } sece_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_WDATA,
        ST_ERASE,
        ST_READ,
        ST_HOLD,
        ST_PROG
    } sece_state_t;

endpackage

// [logic/sece_engine.sv]
// serial eeprom command engine: pin sampling, command decode, array, program timer
// Function
// - after the last address bit of a read, output goes from hi-z to low
// - each word leaves as sixteen bits, msb first
// - continued clocks with select high stream the next word
// - read address wraps from all ones to zero
// - program and erase start when select falls after a complete command
// - a program or erase cycle ends within ten milliseconds
// - select high during programming shows low while busy, high when done
// - during programming all clock and data input is ignored
// - a new instruction is taken only after ready or from hi-z
// - a start bit seen while showing ready returns output to hi-z
// - with more than sixteen data bits only the last sixteen count
// - program writes the word directly, no prior erase needed
// - erase sets all sixteen bits of the addressed word to one
// - enable command sets the write latch, disable command clears it
// - the write latch comes up disabled
// - start bit is serial input high on a rising clock with select high
// - clocks with serial input low before a start bit are ignored
// - select low means standby; falling select ends instruction input
// - array holds 256 or 512 sixteen bit words
// - fields arrive as start bit, opcode, address, then data
`timescale 1ns/1ps

// ----------------------------------------
// read prefetch fifo
// ----------------------------------------
module sece_fifo
    import sece_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin
            $error("fifo depth must be a power of two");
        end
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW:0] wr_ptr_r;
    logic [PW:0] rd_ptr_r;

    assign in_ready = (wr_ptr_r[PW] == rd_ptr_r[PW]) || (wr_ptr_r[PW-1:0] != rd_ptr_r[PW-1:0]);
    assign out_valid = wr_ptr_r != rd_ptr_r;
    assign out_data = mem_r[rd_ptr_r[PW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (in_valid && in_ready && !flush) begin
            mem_r[wr_ptr_r[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------
// command engine top
// ----------------------------------------
module sece_engine
    import sece_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_SMALL,
    parameter int PROG_CYCLES = PROG_TYP_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // host pins
    input wire logic chip_select,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    // serial output, tri-state
    output logic serial_out,
    output logic serial_out_oe_n
);
    localparam int WORDS = 1 << ADDR_W;
    localparam int AFIELD = (ADDR_W == ADDR_W_LARGE) ? AFIELD_LARGE : AFIELD_SMALL;
    localparam int CMD_W = OP_W + AFIELD;

    initial begin
        if (ADDR_W != ADDR_W_SMALL && ADDR_W != ADDR_W_LARGE) begin
            $error("address width must be 8 or 9");
        end
        if (PROG_CYCLES < 1 || PROG_CYCLES > PROG_MAX_CYC) begin
            $error("program cycle count out of range");
        end
    end

    // ----------------------------------------
    // pin synchronisers and edges
    // ----------------------------------------
    sece_pins_t pin_s1_r;
    sece_pins_t pin_s2_r;
    sece_pins_t pin_d_r;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_d_r <= '0;
        end else begin
            pin_s1_r <= '{cs: chip_select, sk: serial_clock_in, di: serial_in};
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end

    logic cs;
    logic di;
    logic sk_rise;
    assign cs = pin_s2_r.cs;
    assign di = pin_s2_r.di;
    assign sk_rise = pin_s2_r.sk && !pin_d_r.sk && cs;

    // ----------------------------------------
    // state and command decode
    // ----------------------------------------
    sece_state_t state_r;
    logic [CMD_W-1:0] cmd_sh_r;
    logic [3:0] cmd_cnt_r;
    logic [15:0] wdata_r;
    logic [4:0] dcnt_r;
    logic [ADDR_W-1:0] addr_r;
    logic [15:0] prog_word_r;
    logic show_ready_r;
    logic wel_r;
    logic [PROG_CNT_W-1:0] prog_cnt_r;
    logic prog_done;

    logic [CMD_W-1:0] cmd_nxt;
    logic cmd_done;
    logic start_seen;
    logic [1:0] op;
    logic [1:0] misc_sel;
    logic prog_go;
    logic erase_go;

    assign cmd_nxt = {cmd_sh_r[CMD_W-2:0], di};
    assign cmd_done = (state_r == ST_CMD) && sk_rise && (cmd_cnt_r == 4'(CMD_W - 1));
    assign op = cmd_nxt[CMD_W-1 -: OP_W];
    assign misc_sel = cmd_nxt[AFIELD-1 -: 2];
    assign start_seen = (state_r == ST_IDLE) && sk_rise && di;
    assign prog_go = (state_r == ST_WDATA) && !cs && wel_r && (dcnt_r == DATA_FULL_CNT);
    assign erase_go = (state_r == ST_ERASE) && !cs && wel_r;
    assign prog_done = (state_r == ST_PROG) && (prog_cnt_r == PROG_CNT_W'(PROG_CYCLES - 1));

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            cmd_cnt_r <= '0;
            cmd_sh_r <= '0;
            addr_r <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    cmd_cnt_r <= '0;
                    if (start_seen) begin
                        state_r <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (!cs) begin
                        state_r <= ST_IDLE;
                    end else if (sk_rise) begin
                        cmd_sh_r <= cmd_nxt;
                        cmd_cnt_r <= cmd_cnt_r + 4'h1;
                        if (cmd_done) begin
                            addr_r <= cmd_nxt[ADDR_W-1:0];
                            unique case (op)
                                OP_READ: state_r <= ST_READ;
                                OP_PROG: state_r <= ST_WDATA;
                                OP_ERASE: state_r <= ST_ERASE;
                                OP_MISC: state_r <= ST_HOLD;
                            endcase
                        end
                    end
                end
                ST_WDATA: begin
                    if (!cs) begin
                        state_r <= prog_go ? ST_PROG : ST_IDLE;
                    end
                end
                ST_ERASE: begin
                    if (!cs) begin
                        state_r <= erase_go ? ST_PROG : ST_IDLE;
                    end
                end
                ST_READ, ST_HOLD: begin
                    if (!cs) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_PROG: begin
                    if (prog_done) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // write data capture
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wdata_r <= '0;
            dcnt_r <= '0;
        end else if (state_r != ST_WDATA) begin
            dcnt_r <= '0;
        end else if (sk_rise) begin
            wdata_r <= {wdata_r[14:0], di};
            if (dcnt_r != DATA_FULL_CNT) begin
                dcnt_r <= dcnt_r + 5'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prog_word_r <= '0;
        end else if (prog_go) begin
            prog_word_r <= wdata_r;
        end else if (erase_go) begin
            prog_word_r <= ERASED_WORD;
        end
    end

    // ----------------------------------------
    // write enable latch
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wel_r <= 1'b0;
        end else if (cmd_done && op == OP_MISC) begin
            if (misc_sel == MISC_ENABLE) begin
                wel_r <= 1'b1;
            end else if (misc_sel == MISC_DISABLE) begin
                wel_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // program timer and array
    // ----------------------------------------
    logic [15:0] array_r [WORDS];

    always_ff @(posedge ref_clk) begin
        if (sys_rst || state_r != ST_PROG) begin
            prog_cnt_r <= '0;
        end else begin
            prog_cnt_r <= prog_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (prog_done) begin
            array_r[addr_r] <= prog_word_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            show_ready_r <= 1'b0;
        end else if (prog_done) begin
            show_ready_r <= 1'b1;
        end else if (start_seen) begin
            show_ready_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // read prefetch and shifter
    // ----------------------------------------
    logic [ADDR_W-1:0] pf_addr_r;
    logic pf_ready;
    logic rd_valid;
    logic rd_pop;
    logic [15:0] rd_word;
    logic [15:0] rd_sh_r;
    logic [3:0] rd_cnt_r;
    logic rd_bit_r;
    logic in_read;

    assign in_read = state_r == ST_READ;
    assign rd_pop = in_read && sk_rise && (rd_cnt_r == 4'h0);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pf_addr_r <= '0;
        end else if (cmd_done) begin
            pf_addr_r <= cmd_nxt[ADDR_W-1:0];
        end else if (in_read && pf_ready) begin
            pf_addr_r <= pf_addr_r + 1'b1;
        end
    end

    sece_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .flush(!in_read),
        .in_valid(in_read),
        .in_ready(pf_ready),
        .in_data(array_r[pf_addr_r]),
        .out_valid(rd_valid),
        .out_ready(rd_pop),
        .out_data(rd_word)
    );

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !in_read) begin
            rd_sh_r <= '0;
            rd_cnt_r <= '0;
            rd_bit_r <= 1'b0;
        end else if (rd_pop) begin
            rd_bit_r <= rd_valid ? rd_word[15] : 1'b0;
            rd_sh_r <= {rd_word[14:0], 1'b0};
            rd_cnt_r <= 4'hf;
        end else if (sk_rise) begin
            rd_bit_r <= rd_sh_r[15];
            rd_sh_r <= {rd_sh_r[14:0], 1'b0};
            rd_cnt_r <= rd_cnt_r - 4'h1;
        end
    end

    // ----------------------------------------
    // serial output driver
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !cs) begin
            serial_out <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end else if (state_r == ST_PROG) begin
            serial_out <= 1'b0;
            serial_out_oe_n <= 1'b0;
        end else if (state_r == ST_IDLE && show_ready_r) begin
            serial_out <= 1'b1;
            serial_out_oe_n <= 1'b0;
        end else if (in_read) begin
            serial_out <= rd_bit_r;
            serial_out_oe_n <= 1'b0;
        end else begin
            serial_out <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_start_ready;
        start_seen && show_ready_r && cs;
    endsequence

    sequence s_read_launch;
        cmd_done && op == OP_READ;
    endsequence

    a_standby_hiz: assert property (!cs |=> serial_out_oe_n)
        else $error("output driven while deselected");
    a_busy_low: assert property (state_r == ST_PROG && cs |=> !serial_out_oe_n && !serial_out)
        else $error("busy level not low");
    a_ready_high: assert property (state_r == ST_IDLE && show_ready_r && cs
        |=> !serial_out_oe_n && serial_out)
        else $error("ready level not high");
    a_start_hiz: assert property (s_start_ready ##1 cs |=> serial_out_oe_n)
        else $error("output not released on start bit");
    a_read_low: assert property (s_read_launch ##1 cs |=> !serial_out_oe_n && !serial_out)
        else $error("read did not drive low");
    a_prog_start: assert property (prog_go |=> state_r == ST_PROG ##1 state_r == ST_PROG)
        else $error("program cycle not started");
    a_erase_ones: assert property (erase_go |=> prog_word_r == ERASED_WORD)
        else $error("erase word not all ones");
    a_prog_ignore: assert property (state_r == ST_PROG && !prog_done |=> state_r == ST_PROG)
        else $error("program cycle disturbed");
    a_prog_bound: assert property (prog_cnt_r < PROG_CNT_W'(PROG_MAX_CYC))
        else $error("program cycle too long");
    a_wel_reset: assert property ($past(sys_rst) |-> !wel_r)
        else $error("write latch not disabled at start");
    a_addr_wrap: assert property (in_read && pf_ready && &pf_addr_r && !cmd_done
        |=> pf_addr_r == '0)
        else $error("read address did not wrap");
endmodule

// [test/sece_host.sv]
// host model driving select, serial clock and serial data of the command engine
`timescale 1ns/1ps

module sece_host
    import sece_pkg::*;
#(
    parameter int AFW = AFIELD_SMALL
) (
    // clock
    input wire logic ref_clk,
    // pins toward the engine
    output sece_pins_t pins,
    input wire logic serial_out,
    input wire logic serial_out_oe_n
);

    initial begin
        pins = 3'h0;
    end

    // ----------------------------------------
    // pin tasks
    // ----------------------------------------
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // select change, then eight ref cycles of setup or deselect
    task automatic sel(input logic v);
        @(negedge ref_clk);
        pins.cs = v;
        wait_n(8);
    endtask

    // one serial clock of 160 ns; q and z are the output just before the rise
    task automatic clk_bit(input logic d, output logic q, output logic z);
        pins.di = d;
        wait_n(4);
        q = serial_out;
        z = serial_out_oe_n;
        pins.sk = 1'b1;
        wait_n(4);
        pins.sk = 1'b0;
    endtask

    // dummy clocks, start bit, opcode, address, data, msb first
    task automatic send(input int dummy, input logic [1:0] op,
                        input logic [AFIELD_LARGE-1:0] a, input logic [16:0] d, input int nd);
        logic q;
        logic z;
        repeat (dummy) clk_bit(1'b0, q, z);
        clk_bit(1'b1, q, z);
        for (int i = 1; i >= 0; i--) clk_bit(op[i], q, z);
        for (int i = AFW - 1; i >= 0; i--) clk_bit(a[i], q, z);
        for (int i = nd - 1; i >= 0; i--) clk_bit(d[i], q, z);
        pins.di = 1'b0;
    endtask

endmodule

// [test/tb.sv]
// self-checking testbench of the serial eeprom command engine
`timescale 1ns/1ps

module tb
    import sece_pkg::*;
;
    localparam int PROG_SIM = 100;

    logic ref_clk;
    logic sys_rst;
    sece_pins_t pins;
    logic serial_out;
    logic serial_out_oe_n;
    sece_pins_t pins_l;
    logic serial_out_l;
    logic serial_out_oe_n_l;
    int mismatches;
    int n_checks;
    int cyc;

    // ----------------------------------------
    // design and host
    // ----------------------------------------
    sece_engine #(.ADDR_W(8), .PROG_CYCLES(PROG_SIM)) i_dut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .chip_select(pins.cs),
        .serial_clock_in(pins.sk),
        .serial_in(pins.di),
        .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n)
    );

    sece_host i_host (
        .ref_clk(ref_clk),
        .pins(pins),
        .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n)
    );

    // second engine with the large array and ten bit address field
    sece_engine #(.ADDR_W(ADDR_W_LARGE), .PROG_CYCLES(PROG_SIM)) i_dut_l (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .chip_select(pins_l.cs),
        .serial_clock_in(pins_l.sk),
        .serial_in(pins_l.di),
        .serial_out(serial_out_l),
        .serial_out_oe_n(serial_out_oe_n_l)
    );

    sece_host #(.AFW(AFIELD_LARGE)) i_host_l (
        .ref_clk(ref_clk),
        .pins(pins_l),
        .serial_out(serial_out_l),
        .serial_out_oe_n(serial_out_oe_n_l)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            mismatches++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // command framed by select
    task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic [16:0] d,
                       input int nd);
        i_host.sel(1'b1);
        i_host.send(0, op, {2'h0, a}, d, nd);
        i_host.sel(1'b0);
    endtask

    // command to the large engine, then room for a program cycle
    task automatic cmd_l(input logic [1:0] op, input logic [9:0] a, input logic [16:0] d,
                         input int nd);
        i_host_l.sel(1'b1);
        i_host_l.send(0, op, a, d, nd);
        i_host_l.sel(1'b0);
        i_host_l.wait_n(PROG_SIM + 20);
    endtask

    // hold select high until ready shows
    task automatic wait_ready();
        int k;
        i_host.sel(1'b1);
        k = 0;
        while (!(serial_out === 1'b1 && serial_out_oe_n === 1'b0) && k < 400) begin
            i_host.wait_n(1);
            k++;
        end
        check("ready within limit", {15'h0, k < 400}, 16'h1);
        i_host.sel(1'b0);
    endtask

    // read n words from a, with three dummy clocks first
    task automatic rd(input logic [7:0] a, input int n, input logic [15:0] e0,
                      input logic [15:0] e1);
        logic q;
        logic z;
        logic [15:0] w;
        i_host.sel(1'b1);
        i_host.send(3, OP_READ, {2'h0, a}, 17'h0, 0);
        i_host.clk_bit(1'b0, q, z);
        check("read lead bit", {14'h0, z, q}, 16'h0);
        for (int k = 0; k < n; k++) begin
            for (int b = 15; b >= 0; b--) begin
                i_host.clk_bit(1'b0, q, z);
                w[b] = q;
            end
            check("read word", w, (k == 0) ? e0 : e1);
        end
        i_host.sel(1'b0);
        check("hi-z after deselect", {15'h0, serial_out_oe_n}, 16'h1);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_up();
        check("reset output", {14'h0, serial_out_oe_n, serial_out}, 16'h2);
        cmd(OP_PROG, 8'h05, 17'h01111, 16);
        i_host.sel(1'b1);
        check("no busy when disabled", {15'h0, serial_out_oe_n}, 16'h1);
        i_host.sel(1'b0);
        $display("test power_up done");
    endtask

    task automatic t_prog_busy();
        logic q;
        logic z;
        int k;
        cmd(OP_MISC, 8'hc0, 17'h0, 0);
        cmd(OP_PROG, 8'hff, 17'h11234, 17);
        i_host.sel(1'b1);
        check("busy level", {14'h0, serial_out_oe_n, serial_out}, 16'h0);
        i_host.clk_bit(1'b1, q, z);
        i_host.clk_bit(1'b1, q, z);
        i_host.clk_bit(1'b0, q, z);
        check("input ignored", {14'h0, serial_out_oe_n, serial_out}, 16'h0);
        k = 0;
        while (serial_out !== 1'b1 && k < 20) begin
            i_host.sel(1'b0);
            i_host.sel(1'b1);
            k++;
        end
        check("ready by toggling", {14'h0, serial_out_oe_n, serial_out}, 16'h1);
        i_host.clk_bit(1'b1, q, z);
        i_host.wait_n(2);
        check("start bit clears", {15'h0, serial_out_oe_n}, 16'h1);
        i_host.sel(1'b0);
        $display("test prog_busy done");
    endtask

    task automatic t_erase_write();
        cmd(OP_ERASE, 8'h00, 17'h0, 0);
        wait_ready();
        rd(8'h00, 1, ERASED_WORD, 16'h0);
        cmd(OP_PROG, 8'h00, 17'h000f0, 16);
        wait_ready();
        rd(8'hff, 2, 16'h1234, 16'h00f0);
        $display("test erase_write done");
    endtask

    task automatic t_disable();
        cmd(OP_MISC, 8'h00, 17'h0, 0);
        cmd(OP_PROG, 8'hff, 17'h0, 16);
        i_host.sel(1'b1);
        check("disabled write refused", {15'h0, serial_out_oe_n}, 16'h1);
        i_host.sel(1'b0);
        rd(8'hff, 1, 16'h1234, 16'h0);
        $display("test disable done");
    endtask

    task automatic t_large();
        logic q;
        logic z;
        logic [15:0] w;
        cmd_l(OP_MISC, 10'h300, 17'h0, 0);
        cmd_l(OP_PROG, 10'h1ff, 17'h0a5c3, 16);
        cmd_l(OP_PROG, 10'h200, 17'h03c5a, 16);
        cmd_l(OP_PROG, 10'h1ff, 17'h00000, 15);
        cmd_l(OP_MISC, 10'h000, 17'h0, 0);
        i_host_l.sel(1'b1);
        i_host_l.send(0, OP_READ, 10'h1ff, 17'h0, 0);
        i_host_l.clk_bit(1'b0, q, z);
        check("large lead bit", {14'h0, z, q}, 16'h0);
        for (int k = 0; k < 2; k++) begin
            for (int b = 15; b >= 0; b--) begin
                i_host_l.clk_bit(1'b0, q, z);
                w[b] = q;
            end
            check("large word", w, (k == 0) ? 16'ha5c3 : 16'h3c5a);
        end
        i_host_l.sel(1'b0);
        check("large hi-z", {15'h0, serial_out_oe_n_l}, 16'h1);
        $display("test large done");
    endtask

    // ----------------------------------------
    // main sequence and timeout
    // ----------------------------------------
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        sys_rst = 1'b1;
        mismatches = 0;
        n_checks = 0;
        cyc = 0;
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        i_host.wait_n(4);
        t_power_up();
        t_prog_busy();
        t_erase_write();
        t_disable();
        t_large();
        conclude();
    end

endmodule
